// file: jtag_pwr_defines.svh
// Purpose: Shared constants of the test port and power-up sequencer.
// Assumes: Core clock of 200 MHz.
// Notes: Times are kept in their own unit; switchover cycle counts derive from them.
`ifndef JTAG_PWR_DEFINES_SVH
`define JTAG_PWR_DEFINES_SVH
`define IR_W 8
`define IR_EXTEST 8'h00
`define IR_IDCODE 8'h01
`define IR_INTEST 8'h02
`define IR_PRELOAD 8'h03
`define IR_CLAMP 8'hfa
`define IR_HIGHZ 8'hfc
`define IR_USERCODE 8'hfd
`define IR_BYPASS 8'hff
`define IR_CAPTURE 8'h01
`define PINS 8
`define ID_W 32
// Arbitrary neutral identification values.
`define IDCODE_DEF 32'h0a5a_5001
`define USERCODE_DEF 32'h0000_0000
`define CLK_MHZ 200
`define TCK_MAX_MHZ 66
`define SW_MIN_US 50
`define SW_MAX_US 300
`define SW_MIN_CYC (`SW_MIN_US * `CLK_MHZ)
`define SW_MAX_CYC (`SW_MAX_US * `CLK_MHZ)
`define COPY_CYC 8
`define CNT_W 16
`endif

// file: jtag_pwr_pkg.sv
// Purpose: Types shared by the test port and power-up sequencer.
// Assumes: Nothing beyond the constants header.
// Notes: Tap state codes follow the usual four-bit encoding.
`include "jtag_pwr_defines.svh"
package jtag_pwr_pkg;
    typedef enum logic [2:0] {
        PWR_QUIET = 3'h0,
        PWR_COPY = 3'h1,
        PWR_ERASED = 3'h2,
        PWR_RUN = 3'h3,
        PWR_SWITCH = 3'h4
    } pwr_state_t;
    typedef enum logic [3:0] {
        TAP_EX2_DR = 4'h0,
        TAP_EX1_DR = 4'h1,
        TAP_SH_DR = 4'h2,
        TAP_PA_DR = 4'h3,
        TAP_SEL_IR = 4'h4,
        TAP_UPD_DR = 4'h5,
        TAP_CAP_DR = 4'h6,
        TAP_SEL_DR = 4'h7,
        TAP_EX2_IR = 4'h8,
        TAP_EX1_IR = 4'h9,
        TAP_SH_IR = 4'ha,
        TAP_PA_IR = 4'hb,
        TAP_IDLE = 4'hc,
        TAP_UPD_IR = 4'hd,
        TAP_CAP_IR = 4'he,
        TAP_TLR = 4'hf
    } tap_state_t;
    typedef enum logic [1:0] {
        DR_BYP = 2'h0,
        DR_ID = 2'h1,
        DR_USR = 2'h2,
        DR_BSR = 2'h3
    } dr_sel_t;
    typedef struct packed {
        logic [`PINS-1:0] oe;
        logic [`PINS-1:0] out;
        logic [`PINS-1:0] inp;
    } bscan_t;
endpackage : jtag_pwr_pkg

// file: tap_fsm.sv
// Purpose: Test access port state machine stepped on sampled clock edges.
// Assumes: Rising test clock edge arrives as a one-cycle pulse.
// Notes: Held in reset state while the port is disabled.
`timescale 1ns/1ps
module tap_fsm (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic tck_rise_i,
    input wire logic tms_i,
    output jtag_pwr_pkg::tap_state_t state_o
);
    function automatic jtag_pwr_pkg::tap_state_t step(
        input jtag_pwr_pkg::tap_state_t s, input logic m);
        case (s)
            jtag_pwr_pkg::TAP_TLR:
                step = m ? jtag_pwr_pkg::TAP_TLR : jtag_pwr_pkg::TAP_IDLE;
            jtag_pwr_pkg::TAP_IDLE, jtag_pwr_pkg::TAP_UPD_DR,
            jtag_pwr_pkg::TAP_UPD_IR:
                step = m ? jtag_pwr_pkg::TAP_SEL_DR : jtag_pwr_pkg::TAP_IDLE;
            jtag_pwr_pkg::TAP_SEL_DR:
                step = m ? jtag_pwr_pkg::TAP_SEL_IR : jtag_pwr_pkg::TAP_CAP_DR;
            jtag_pwr_pkg::TAP_CAP_DR, jtag_pwr_pkg::TAP_SH_DR:
                step = m ? jtag_pwr_pkg::TAP_EX1_DR : jtag_pwr_pkg::TAP_SH_DR;
            jtag_pwr_pkg::TAP_EX2_DR:
                step = m ? jtag_pwr_pkg::TAP_UPD_DR : jtag_pwr_pkg::TAP_SH_DR;
            jtag_pwr_pkg::TAP_EX1_DR, jtag_pwr_pkg::TAP_PA_DR:
                step = m ? (s == jtag_pwr_pkg::TAP_PA_DR ?
                    jtag_pwr_pkg::TAP_EX2_DR : jtag_pwr_pkg::TAP_UPD_DR)
                    : jtag_pwr_pkg::TAP_PA_DR;
            jtag_pwr_pkg::TAP_SEL_IR:
                step = m ? jtag_pwr_pkg::TAP_TLR : jtag_pwr_pkg::TAP_CAP_IR;
            jtag_pwr_pkg::TAP_CAP_IR, jtag_pwr_pkg::TAP_SH_IR:
                step = m ? jtag_pwr_pkg::TAP_EX1_IR : jtag_pwr_pkg::TAP_SH_IR;
            jtag_pwr_pkg::TAP_EX2_IR:
                step = m ? jtag_pwr_pkg::TAP_UPD_IR : jtag_pwr_pkg::TAP_SH_IR;
            jtag_pwr_pkg::TAP_EX1_IR, jtag_pwr_pkg::TAP_PA_IR:
                step = m ? (s == jtag_pwr_pkg::TAP_PA_IR ?
                    jtag_pwr_pkg::TAP_EX2_IR : jtag_pwr_pkg::TAP_UPD_IR)
                    : jtag_pwr_pkg::TAP_PA_IR;
            default:
                step = jtag_pwr_pkg::TAP_TLR;
        endcase
    endfunction : step

    // RULE20 standard tap sequence.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_o <= jtag_pwr_pkg::TAP_TLR;
        else if (!enable_i)
            state_o <= jtag_pwr_pkg::TAP_TLR;
        else if (tck_rise_i)
            state_o <= step(state_o, tms_i);
    end
endmodule : tap_fsm

// file: jtag_powerup_config_control.sv
// Purpose: Boundary-scan test port and power-up sequencer of the device.
// Assumes: Test clock and pins are asynchronous and are sampled here.
// Notes: Pin controls are registered, so they follow state by one cycle.
`timescale 1ns/1ps
`include "jtag_pwr_defines.svh"
// Contract
// RULE1 - Extest drives boundary-scan output cells onto the pins.
// RULE2 - Preload captures present core data into boundary-scan cells.
// RULE3 - Bypass puts one bit between test data in and out.
// RULE4 - Intest feeds boundary-scan input cells to internal logic.
// RULE5 - Highz instruction floats every user output.
// RULE6 - Clamp holds latched outputs while bypass is scanned.
// RULE7 - Test clock up to 66 MHz works; controller stays below.
// RULE8 - Reload programming proceeds while the old pattern keeps running.
// RULE9 - During pattern switchover pins float with weak pullups.
// RULE10 - Switchover lasts between 50 and 300 microseconds.
// RULE11 - All pins stay disabled until power-up finishes.
// RULE12 - Configuration is copied from storage into volatile cells.
// RULE13 - Stay quiescent until core supply reaches a safe level.
// RULE14 - Quiescent: test port off, outputs off, pins pulled up.
// RULE15 - At safe supply, init user registers and run at once.
// RULE16 - Erased device keeps outputs off with weak pullups.
// RULE17 - Erased device keeps the test port enabled.
// RULE18 - Programmed device runs pins as its configuration defines.
// RULE19 - Programmed device keeps the test port enabled. The port is off during each copy, including the copy after a switchover.
// RULE20 - Tap states, shifting and id reset follow the standard.
// RULE21 - Id and usercode registers; unknown codes pick bypass.
module jtag_powerup_config_control #(
    parameter int unsigned SWITCH_CYCLES = `SW_MIN_CYC,
    parameter logic [`ID_W-1:0] USERCODE = `USERCODE_DEF
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic supply_safe_i,
    input wire logic programmed_i,
    input wire logic reload_req_i,
    input wire logic [`PINS-1:0] core_out_i,
    input wire logic [`PINS-1:0] core_oe_i,
    input wire logic [`PINS-1:0] pin_in_i,
    output logic [`PINS-1:0] pin_out_o,
    output logic [`PINS-1:0] pin_oe_o,
    output logic pin_pullup_o,
    output logic [`PINS-1:0] core_in_o,
    output logic cfg_copy_o,
    output logic user_init_o,
    output logic reload_busy_o,
    output logic logic_run_o
);
    localparam int SYN_W = 6 + `PINS;
    localparam logic [`CNT_W-1:0] COPY_LAST = `CNT_W'(`COPY_CYC - 1);
    localparam logic [`CNT_W-1:0] SW_LAST = `CNT_W'(SWITCH_CYCLES - 1);

    logic [SYN_W-1:0] meta_q;
    logic [SYN_W-1:0] sync_q;
    logic tck_s, tms_s, tdi_s, safe_s, prog_s, reload_s;
    logic [`PINS-1:0] pin_s;
    logic tck_d_q, tck_rise, tck_fall;
    logic reload_d_q;
    jtag_pwr_pkg::pwr_state_t pwr_q;
    logic [`CNT_W-1:0] cnt_q;
    jtag_pwr_pkg::tap_state_t tap;
    logic port_en;
    logic [`IR_W-1:0] ir_q, ir_sh_q;
    logic bypass_q;
    logic [`ID_W-1:0] id_sh_q;
    jtag_pwr_pkg::bscan_t bsr_sh_q, bsr_upd_q;
    jtag_pwr_pkg::dr_sel_t dsel;

    function automatic jtag_pwr_pkg::dr_sel_t dr_of(input logic [7:0] ir);
        case (ir)
            `IR_EXTEST, `IR_PRELOAD, `IR_INTEST: dr_of = jtag_pwr_pkg::DR_BSR;
            `IR_IDCODE: dr_of = jtag_pwr_pkg::DR_ID;
            `IR_USERCODE: dr_of = jtag_pwr_pkg::DR_USR;
            default: dr_of = jtag_pwr_pkg::DR_BYP;
        endcase
    endfunction : dr_of

    // Every pin-side input is sampled twice before any use.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= {tck_i, tms_i, tdi_i, supply_safe_i, programmed_i,
                       reload_req_i, pin_in_i};
            sync_q <= meta_q;
        end
    end
    assign {tck_s, tms_s, tdi_s, safe_s, prog_s, reload_s, pin_s} = sync_q;

    // RULE7 test clock edge detect.
    // A 66 MHz test clock leaves at least one sample per phase at 200 MHz.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tck_d_q <= 1'b0;
        else
            tck_d_q <= tck_s;
    end
    assign tck_rise = tck_s & ~tck_d_q;
    assign tck_fall = ~tck_s & tck_d_q;

    // RULE13 quiescent until supply safe.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pwr_q <= jtag_pwr_pkg::PWR_QUIET;
        else if (!safe_s)
            pwr_q <= jtag_pwr_pkg::PWR_QUIET;
        else
            case (pwr_q)
                jtag_pwr_pkg::PWR_QUIET:
                    pwr_q <= jtag_pwr_pkg::PWR_COPY;
                jtag_pwr_pkg::PWR_COPY:
                    // RULE15 run at once after copy.
                    if (cnt_q == COPY_LAST)
                        pwr_q <= prog_s ? jtag_pwr_pkg::PWR_RUN
                                        : jtag_pwr_pkg::PWR_ERASED;
                jtag_pwr_pkg::PWR_ERASED:
                    if (prog_s)
                        pwr_q <= jtag_pwr_pkg::PWR_COPY;
                jtag_pwr_pkg::PWR_RUN:
                    // RULE8 old pattern keeps running.
                    if (reload_d_q && !reload_s)
                        pwr_q <= jtag_pwr_pkg::PWR_SWITCH;
                jtag_pwr_pkg::PWR_SWITCH:
                    // RULE10 switchover length.
                    if (cnt_q == SW_LAST)
                        pwr_q <= jtag_pwr_pkg::PWR_COPY;
                default:
                    pwr_q <= jtag_pwr_pkg::PWR_QUIET;
            endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_q <= '0;
        else if ((pwr_q == jtag_pwr_pkg::PWR_COPY && cnt_q != COPY_LAST) ||
                 (pwr_q == jtag_pwr_pkg::PWR_SWITCH && cnt_q != SW_LAST))
            cnt_q <= cnt_q + `CNT_W'(1);
        else
            cnt_q <= '0;
    end

    // RULE8 reload busy while programming.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reload_d_q <= 1'b0;
            reload_busy_o <= 1'b0;
        end
        else
        begin
            reload_d_q <= reload_s;
            reload_busy_o <= (pwr_q == jtag_pwr_pkg::PWR_RUN) & reload_s;
        end
    end

    // RULE12 copy strobe and RULE15 init pulse.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_copy_o <= 1'b0;
            user_init_o <= 1'b0;
            logic_run_o <= 1'b0;
        end
        else
        begin
            cfg_copy_o <= pwr_q == jtag_pwr_pkg::PWR_COPY;
            user_init_o <= safe_s && pwr_q == jtag_pwr_pkg::PWR_COPY &&
                           cnt_q == COPY_LAST;
            logic_run_o <= pwr_q == jtag_pwr_pkg::PWR_RUN;
        end
    end

    // RULE14 RULE17 RULE19 port enable.
    assign port_en = pwr_q == jtag_pwr_pkg::PWR_ERASED ||
                     pwr_q == jtag_pwr_pkg::PWR_RUN ||
                     pwr_q == jtag_pwr_pkg::PWR_SWITCH;

    tap_fsm u_tap (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .enable_i(port_en),
        .tck_rise_i(tck_rise),
        .tms_i(tms_s),
        .state_o(tap)
    );

    // RULE20 instruction register path.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ir_q <= `IR_IDCODE;
            ir_sh_q <= '0;
        end
        else if (tap == jtag_pwr_pkg::TAP_TLR)
            ir_q <= `IR_IDCODE;
        else if (tck_rise)
            case (tap)
                jtag_pwr_pkg::TAP_CAP_IR: ir_sh_q <= `IR_CAPTURE;
                jtag_pwr_pkg::TAP_SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[7:1]};
                default: ;
            endcase
        else if (tck_fall && tap == jtag_pwr_pkg::TAP_UPD_IR)
            ir_q <= ir_sh_q;
    end

    // RULE21 data register select.
    assign dsel = dr_of(ir_q);

    // RULE3 single-bit bypass.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            bypass_q <= 1'b0;
        else if (tck_rise && tap == jtag_pwr_pkg::TAP_CAP_DR)
            bypass_q <= 1'b0;
        else if (tck_rise && tap == jtag_pwr_pkg::TAP_SH_DR)
            bypass_q <= tdi_s;
    end

    // RULE21 identification and user code.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            id_sh_q <= '0;
        else if (tck_rise && tap == jtag_pwr_pkg::TAP_CAP_DR)
            id_sh_q <= dsel == jtag_pwr_pkg::DR_USR ? USERCODE : `IDCODE_DEF;
        else if (tck_rise && tap == jtag_pwr_pkg::TAP_SH_DR)
            id_sh_q <= {tdi_s, id_sh_q[`ID_W-1:1]};
    end

    // RULE2 capture core and pin data.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bsr_sh_q <= '0;
            bsr_upd_q <= '0;
        end
        else if (dsel == jtag_pwr_pkg::DR_BSR)
        begin
            if (tck_rise && tap == jtag_pwr_pkg::TAP_CAP_DR)
                bsr_sh_q <= {core_oe_i, core_out_i, pin_s};
            else if (tck_rise && tap == jtag_pwr_pkg::TAP_SH_DR)
                bsr_sh_q <= {tdi_s, bsr_sh_q[$bits(bsr_sh_q)-1:1]};
            else if (tck_fall && tap == jtag_pwr_pkg::TAP_UPD_DR)
                bsr_upd_q <= bsr_sh_q;
        end
    end

    // RULE20 output changes on falling test clock.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end
        else if (!port_en)
            tdo_oe_o <= 1'b0;
        else if (tck_fall)
        begin
            tdo_oe_o <= tap == jtag_pwr_pkg::TAP_SH_DR ||
                        tap == jtag_pwr_pkg::TAP_SH_IR;
            if (tap == jtag_pwr_pkg::TAP_SH_IR)
                tdo_o <= ir_sh_q[0];
            else
                case (dsel)
                    jtag_pwr_pkg::DR_BSR: tdo_o <= bsr_sh_q[0];
                    jtag_pwr_pkg::DR_ID,
                    jtag_pwr_pkg::DR_USR: tdo_o <= id_sh_q[0];
                    default: tdo_o <= bypass_q;
                endcase
        end
    end

    // Pin drive; only a running programmed device lets user logic out.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_out_o <= '0;
            pin_oe_o <= '0;
            pin_pullup_o <= 1'b1;
            core_in_o <= '0;
        end
        else
        begin
            // RULE9 RULE11 RULE14 RULE16 pullups when not running.
            pin_pullup_o <= pwr_q != jtag_pwr_pkg::PWR_RUN;
            // RULE4 internal test inputs.
            core_in_o <= ir_q == `IR_INTEST ? bsr_upd_q.inp : pin_s;
            if (pwr_q != jtag_pwr_pkg::PWR_RUN)
            begin
                pin_oe_o <= '0;
                pin_out_o <= '0;
            end
            // RULE5 force high impedance.
            else if (ir_q == `IR_HIGHZ)
                pin_oe_o <= '0;
            // RULE1 RULE6 drive latched cells.
            else if (ir_q == `IR_EXTEST || ir_q == `IR_CLAMP)
            begin
                pin_oe_o <= bsr_upd_q.oe;
                pin_out_o <= bsr_upd_q.out;
            end
            // RULE18 configured operation.
            else
            begin
                pin_oe_o <= core_oe_i;
                pin_out_o <= core_out_i;
            end
        end
    end

    localparam int SW_LAST_I = SWITCH_CYCLES - 1;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_quiet_pins_off: assert property ( // RULE11
        pwr_q != jtag_pwr_pkg::PWR_RUN |=> pin_oe_o == '0)
        else $error("pins enabled before power-up finished");
    a_quiet_port_off: assert property ( // RULE14
        pwr_q == jtag_pwr_pkg::PWR_QUIET |=> !tdo_oe_o && pin_pullup_o)
        else $error("test port or pullup wrong while quiescent");
    a_highz_outputs: assert property ( // RULE5
        ir_q == `IR_HIGHZ |=> pin_oe_o == '0)
        else $error("outputs driven under highz");
    a_extest_drive: assert property ( // RULE1
        pwr_q == jtag_pwr_pkg::PWR_RUN && ir_q == `IR_EXTEST
        |=> pin_out_o == $past(bsr_upd_q.out) &&
            pin_oe_o == $past(bsr_upd_q.oe))
        else $error("extest pins differ from scan cells");
    a_clamp_hold: assert property ( // RULE6
        (pwr_q == jtag_pwr_pkg::PWR_RUN && ir_q == `IR_CLAMP)[*3]
        |-> $stable(pin_out_o) && dsel == jtag_pwr_pkg::DR_BYP)
        else $error("clamp outputs moved");
    a_bypass_shift: assert property ( // RULE3
        tck_rise && tap == jtag_pwr_pkg::TAP_SH_DR
        |=> bypass_q == $past(tdi_s))
        else $error("bypass bit not loaded from tdi");
    a_reset_idcode: assert property ( // RULE20
        tap == jtag_pwr_pkg::TAP_TLR |=> ir_q == `IR_IDCODE)
        else $error("instruction not reset to idcode");
    a_switch_length: assert property ( // RULE10
        $past(pwr_q) == jtag_pwr_pkg::PWR_SWITCH &&
        pwr_q == jtag_pwr_pkg::PWR_COPY |-> $past(cnt_q) == SW_LAST_I)
        else $error("switchover left early");
    a_switch_float: assert property ( // RULE9
        pwr_q == jtag_pwr_pkg::PWR_SWITCH |=> pin_pullup_o && pin_oe_o == '0)
        else $error("pins not floating in switchover");
    a_init_then_run: assert property ( // RULE15
        pwr_q == jtag_pwr_pkg::PWR_COPY && cnt_q == COPY_LAST && safe_s
        |=> user_init_o && (pwr_q == jtag_pwr_pkg::PWR_RUN ||
                            pwr_q == jtag_pwr_pkg::PWR_ERASED))
        else $error("no init or run after copy");
    a_intest_feed: assert property ( // RULE4
        ir_q == `IR_INTEST |=> core_in_o == $past(bsr_upd_q.inp))
        else $error("intest input not from scan cells");

    c_run: cover property (pwr_q == jtag_pwr_pkg::PWR_RUN);
    c_switch: cover property (pwr_q == jtag_pwr_pkg::PWR_SWITCH);
    c_erased_shift: cover property (
        pwr_q == jtag_pwr_pkg::PWR_ERASED && tap == jtag_pwr_pkg::TAP_SH_DR);
    c_extest: cover property (ir_q == `IR_EXTEST && pin_oe_o != '0);
endmodule : jtag_powerup_config_control

// file: jtag_host_model.sv
// Purpose: Behavioural test controller that drives the device's test port.
// Assumes: Test clock period of 64 ns, idling low between frames.
// Notes: Data in flips after each frame so stale bits are never trusted.
`timescale 1ns/1ps
module jtag_host_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    logic oe_seen;
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        oe_seen = 1'b0;
    end
    // clock rate
    // A 32 ns half period keeps the test clock far under 66 MHz.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #32;
        // A released output reads as the inverse, so it never passes as data.
        tdo = tdo_oe_i ? tdo_i : ~tdo_i;
        if (tdo_oe_i === 1'b1)
            oe_seen = 1'b1;
        tck_o = 1'b1;
        #32;
        tck_o = 1'b0;
    endtask : step
    task automatic tap_reset();
        logic t;
        repeat (5) step(1'b1, 1'b0, t);
        step(1'b0, 1'b1, t);
    endtask : tap_reset
    // Starts and ends in the idle state; bits go least significant first.
    task automatic scan(input logic ir, input int w, input logic [31:0] din,
                        output logic [31:0] dout);
        logic t;
        dout = '0;
        step(1'b1, tdi_o, t);
        if (ir)
            step(1'b1, tdi_o, t);
        step(1'b0, tdi_o, t);
        step(1'b0, tdi_o, t);
        for (int i = 0; i < w; i++)
        begin
            step(i == w - 1, din[i], t);
            dout[i] = t;
        end
        step(1'b1, ~tdi_o, t);
        step(1'b0, tdi_o, t);
    endtask : scan
endmodule : jtag_host_model

// file: testbench.sv
// Purpose: Self-checking bench of the test port and power-up sequencer.
// Assumes: Switchover shortened to 20 cycles through its parameter.
// Notes: Random core and pin values come from a fixed seed.
`timescale 1ns/1ps
`include "jtag_pwr_defines.svh"
module testbench;
    // Arbitrary user code value.
    localparam logic [31:0] USR = 32'h0000_5a5a;
    logic clock_i, resetn_i, tck, tms, tdi, tdo_o, tdo_oe_o;
    logic supply_safe_i, programmed_i, reload_req_i;
    logic [7:0] core_out_i, core_oe_i, pin_in_i, pin_out_o, pin_oe_o;
    logic [7:0] core_in_o, code;
    logic pin_pullup_o, cfg_copy_o, user_init_o, reload_busy_o, logic_run_o;
    logic [31:0] v, d;
    int err_total, n_checks, cyc, seed, n;
    jtag_host_model u_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));
    jtag_powerup_config_control #(.SWITCH_CYCLES(20), .USERCODE(USR)) u_dut (
        .clock_i(clock_i), .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .supply_safe_i(supply_safe_i), .programmed_i(programmed_i),
        .reload_req_i(reload_req_i), .core_out_i(core_out_i),
        .core_oe_i(core_oe_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
        .core_in_o(core_in_o), .cfg_copy_o(cfg_copy_o),
        .user_init_o(user_init_o), .reload_busy_o(reload_busy_o),
        .logic_run_o(logic_run_o));
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic results();
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            results();
        end
    end
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    task automatic wait_n(input int k);
        repeat (k) @(negedge clock_i);
    endtask : wait_n
    task automatic ir(input logic [7:0] c);
        u_host.scan(1'b1, 8, {24'h0, c}, d);
        chk(d[7:0] === `IR_CAPTURE, "ir capture");
        wait_n(4);
    endtask : ir
    task automatic power_up(input logic prog);
        int c;
        logic bad;
        c = 0;
        bad = 1'b0;
        wait_n(1);
        resetn_i = 1'b0;
        supply_safe_i = 1'b0;
        programmed_i = prog;
        wait_n(6);
        chk(pin_pullup_o === 1'b1 && pin_oe_o === '0, "reset pins");
        resetn_i = 1'b1;
        u_host.oe_seen = 1'b0;
        u_host.scan(1'b1, 8, 32'h1, d);
        chk(u_host.oe_seen === 1'b0 && pin_oe_o === '0, "quiet");
        chk(logic_run_o === 1'b0 && pin_pullup_o === 1'b1, "q");
        wait_n(1);
        supply_safe_i = 1'b1;
        n = 0;
        while (user_init_o !== 1'b1 && n < 40)
        begin
            wait_n(1);
            if (cfg_copy_o === 1'b1)
                c++;
            if (pin_oe_o !== '0)
                bad = 1'b1;
            n++;
        end
        chk(c == `COPY_CYC && user_init_o === 1'b1, "copy");
        chk(bad === 1'b0, "pins on early");
        wait_n(3);
        chk(logic_run_o === prog, "run state");
        u_host.tap_reset();
        wait_n(1);
    endtask : power_up
    initial
    begin
        seed = 93523;
        {resetn_i, supply_safe_i, programmed_i, reload_req_i} = 4'h0;
        {core_out_i, core_oe_i, pin_in_i} = '0;
        power_up(1'b1);
        core_out_i = 8'($random(seed));
        core_oe_i = 8'($random(seed));
        pin_in_i = 8'($random(seed));
        wait_n(4);
        chk(pin_out_o === core_out_i && pin_oe_o === core_oe_i, "pins");
        ir(`IR_IDCODE);
        u_host.scan(1'b0, 32, $random(seed), d);
        chk(d === `IDCODE_DEF, "idcode");
        ir(`IR_USERCODE);
        u_host.scan(1'b0, 32, $random(seed), d);
        chk(d === USR, "usercode");
        for (int k = 0; k < 4; k++)
        begin
            code = 8'hff;
            if (k > 0)
                do code = 8'($random(seed));
                while (code inside {8'h00, 8'h01, 8'h02, 8'h03, 8'hfa,
                                    8'hfc, 8'hfd, 8'hff});
            ir(code);
            v = $random(seed);
            u_host.scan(1'b0, 8, v, d);
            chk(d[7:0] === {v[6:0], 1'b0}, "bypass");
        end
        ir(`IR_PRELOAD);
        v = $random(seed);
        u_host.scan(1'b0, 24, v, d);
        chk(d[23:0] === {core_oe_i, core_out_i, pin_in_i}, "preload");
        ir(`IR_EXTEST);
        chk(pin_out_o === v[15:8] && pin_oe_o === v[23:16], "extest");
        ir(`IR_CLAMP);
        core_out_i = ~core_out_i;
        u_host.scan(1'b0, 8, 32'h5, d);
        chk(d[7:0] === 8'h0a, "clamp path");
        chk(pin_out_o === v[15:8] && pin_oe_o === v[23:16], "clamp");
        ir(`IR_HIGHZ);
        chk(pin_oe_o === '0, "highz");
        ir(`IR_INTEST);
        v = $random(seed);
        u_host.scan(1'b0, 24, v, d);
        wait_n(4);
        chk(core_in_o === v[7:0], "intest");
        ir(`IR_BYPASS);
        reload_req_i = 1'b1;
        wait_n(6);
        chk(reload_busy_o === 1'b1 && logic_run_o === 1'b1, "reload");
        reload_req_i = 1'b0;
        n = 0;
        while (pin_pullup_o !== 1'b1 && n < 10)
        begin
            n++;
            wait_n(1);
        end
        chk(pin_oe_o === '0 && pin_pullup_o === 1'b1, "float");
        n = 0;
        while (cfg_copy_o !== 1'b1 && n < 60)
        begin
            n++;
            wait_n(1);
        end
        chk(n >= 19 && n <= 21, "switch time");
        power_up(1'b0);
        chk(pin_oe_o === '0 && pin_pullup_o === 1'b1, "erased");
        u_host.oe_seen = 1'b0;
        u_host.scan(1'b0, 32, 32'h0, d);
        chk(d === `IDCODE_DEF && u_host.oe_seen === 1'b1, "port");
        results();
    end
endmodule : testbench
